// ---- common/pinmux_pkg.sv ----
package pinmux_pkg;

  // ------------------------------------------------------------
  // Widths
  // ------------------------------------------------------------
  localparam int ADDR_W = 18;
  localparam int DATA_W = 32;
  localparam int PORT_W = 8;
  localparam int IDX_W = 16;

  // ------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ------------------------------------------------------------
  localparam logic [IDX_W-1:0] IDX_PIN_LEVEL = 16'hf258;
  localparam logic [IDX_W-1:0] IDX_DIRECTION = 16'hf259;
  localparam logic [IDX_W-1:0] IDX_CTRL_LOW = 16'hf25a;
  localparam logic [IDX_W-1:0] IDX_CTRL_HIGH = 16'hf25b;
  localparam logic [IDX_W-1:0] IDX_FSEL_LOW = 16'hf25c;
  localparam logic [IDX_W-1:0] IDX_FSEL_HIGH = 16'hf25d;
  localparam logic [IDX_W-1:0] IDX_MODE0 = 16'hf260;

  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic [7:0] RST_PORT = 8'h00;
  localparam logic [7:0] RST_MODE0 = 8'h00;
  localparam logic RX_IDLE = 1'b1;

  // ------------------------------------------------------------
  // Field encodings, written as {high bit, low bit}
  // ------------------------------------------------------------
  localparam logic [1:0] FSEL_PRIMARY = 2'b00;
  localparam logic [1:0] FSEL_TERTIARY = 2'b10;
  localparam logic [1:0] CTRL_HIZ = 2'b00;
  localparam logic [1:0] CTRL_P_OD = 2'b01;
  localparam logic [1:0] CTRL_N_OD = 2'b10;
  localparam logic [1:0] CTRL_CMOS = 2'b11;
  localparam logic DIR_OUT = 1'b0;
  localparam logic DIR_IN = 1'b1;

  // ------------------------------------------------------------
  // Serial pin positions
  // ------------------------------------------------------------
  localparam int TX_PIN_A = 1;
  localparam int RX_PIN_A = 0;
  localparam int TX_PIN_B = 4;
  localparam int RX_PIN_B = 5;
  localparam int RSEL_BIT = 4;

endpackage : pinmux_pkg

// ---- hw/sync_2ff.sv ----
module sync_2ff #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  // Data
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      // Reset to the idle high level of a serial line, so that a receiver
      // behind this stage sees no start bit while the stages refill.
      meta_q <= '1;
      sync_q <= '1;
    end
    else
    begin
      meta_q <= async_i;
      sync_q <= meta_q;
    end
  end

  assign sync_o = sync_q;

endmodule : sync_2ff

// ---- hw/port_pin_cell.sv ----
module port_pin_cell (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  // Configuration
  input wire logic dir_i,
  input wire logic [1:0] ctrl_i,
  input wire logic data_i,
  // Serial takeover
  input wire logic serial_i,
  input wire logic tx_level_i,
  // Pad
  output logic out_o,
  output logic oe_o,
  output logic pull_up_o,
  output logic pull_down_o
);
  import pinmux_pkg::*;

  logic level;

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rstn_i);

  // The data bit is ignored while the serial unit owns the pin.
  assign level = serial_i ? tx_level_i : data_i;

  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      out_o <= 1'b0;
      oe_o <= 1'b0;
      pull_up_o <= 1'b0;
      pull_down_o <= 1'b0;
    end
    else
    begin
      out_o <= level;
      pull_up_o <= (dir_i == DIR_IN) && (ctrl_i == CTRL_N_OD);
      pull_down_o <= (dir_i == DIR_IN) && (ctrl_i == CTRL_P_OD);
      if (dir_i == DIR_IN)
        oe_o <= 1'b0;
      else
      begin
        case (ctrl_i)
          CTRL_CMOS: oe_o <= 1'b1;
          CTRL_P_OD: oe_o <= level;
          CTRL_N_OD: oe_o <= !level;
          default: oe_o <= 1'b0;
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  a_cmos_drive: assert property (
    (dir_i == DIR_OUT && ctrl_i == CTRL_CMOS) |=> oe_o && out_o == $past(level))
    else $error("CMOS pin not driven");
  a_input_float: assert property (
    dir_i == DIR_IN |=> !oe_o)
    else $error("input pin driven");
  a_data_ignored: assert property (
    serial_i |=> out_o == $past(tx_level_i))
    else $error("serial pin follows data bit");
  a_gpio_follow: assert property (
    !serial_i |=> out_o == $past(data_i))
    else $error("port pin ignores data bit");

endmodule : port_pin_cell

// ---- hw/uart_port_pin_routing.sv ----
// Behaviour
// - Pin 1 tertiary drives transmit; pin 0 primary feeds receive.
// - Pin 4 tertiary drives transmit; pin 5 primary can feed receive.
// - Direction 0 with both control bits 1 gives a push-pull output.
// - Direction 1 makes the pin an input, required for receive.
// - Data register bits do not affect pins owned by the serial unit.
// - Mode bit 4 selects receive source: 0 pin 0, 1 pin 5.
// - The select bit wins over port configuration for receive.
// - In receive mode a transmit pin is held high.
//
// Our own choice: the Wishbone slave port.
module uart_port_pin_routing (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [pinmux_pkg::ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [pinmux_pkg::DATA_W-1:0] wb_dat_i,
  output logic [pinmux_pkg::DATA_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  // Serial unit
  input wire logic serial_tx_out_i,
  input wire logic serial_rx_mode_i,
  output logic serial_rx_in_o,
  output logic receive_pin_select_o,
  // Port B pads
  input wire logic [pinmux_pkg::PORT_W-1:0] pin_in_i,
  output logic [pinmux_pkg::PORT_W-1:0] pin_out_o,
  output logic [pinmux_pkg::PORT_W-1:0] pin_oe_o,
  output logic [pinmux_pkg::PORT_W-1:0] pin_pull_up_o,
  output logic [pinmux_pkg::PORT_W-1:0] pin_pull_down_o
);
  import pinmux_pkg::*;

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  logic [PORT_W-1:0] pin_level_q;
  logic [PORT_W-1:0] direction_q;
  logic [PORT_W-1:0] ctrl_low_q;
  logic [PORT_W-1:0] ctrl_high_q;
  logic [PORT_W-1:0] fsel_low_q;
  logic [PORT_W-1:0] fsel_high_q;
  logic [7:0] mode0_q;
  logic ack_q;
  logic [DATA_W-1:0] dat_q;
  logic rx_q;
  logic [PORT_W-1:0] pin_sync;
  logic [PORT_W-1:0] serial_pin;
  logic [PORT_W-1:0] level_rd;
  logic tx_level;
  logic rsel;
  logic access;
  logic wr_en;
  logic [IDX_W-1:0] word_idx;
  logic [7:0] rd_byte;

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rstn_i);

  // ------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------
  // A new access is taken only while ack is low, so every transfer
  // answers exactly once and ack drops in the following cycle.
  assign access = wb_cyc_i && wb_stb_i && !ack_q;
  assign wr_en = access && wb_we_i && wb_sel_i[0];
  assign word_idx = wb_adr_i[ADDR_W-1:2];

  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      ack_q <= 1'b0;
    else
      ack_q <= access;
  end

  // ------------------------------------------------------------
  // Port B registers
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      pin_level_q <= RST_PORT;
    else if (wr_en && word_idx == IDX_PIN_LEVEL)
      pin_level_q <= wb_dat_i[PORT_W-1:0];
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      direction_q <= RST_PORT;
    else if (wr_en && word_idx == IDX_DIRECTION)
      direction_q <= wb_dat_i[PORT_W-1:0];
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      ctrl_low_q <= RST_PORT;
    else if (wr_en && word_idx == IDX_CTRL_LOW)
      ctrl_low_q <= wb_dat_i[PORT_W-1:0];
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      ctrl_high_q <= RST_PORT;
    else if (wr_en && word_idx == IDX_CTRL_HIGH)
      ctrl_high_q <= wb_dat_i[PORT_W-1:0];
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      fsel_low_q <= RST_PORT;
    else if (wr_en && word_idx == IDX_FSEL_LOW)
      fsel_low_q <= wb_dat_i[PORT_W-1:0];
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      fsel_high_q <= RST_PORT;
    else if (wr_en && word_idx == IDX_FSEL_HIGH)
      fsel_high_q <= wb_dat_i[PORT_W-1:0];
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      mode0_q <= RST_MODE0;
    else if (wr_en && word_idx == IDX_MODE0)
      mode0_q <= wb_dat_i[7:0];
  end

  // ------------------------------------------------------------
  // Read path
  // ------------------------------------------------------------
  // Input pins read back their synchronised level, output pins the
  // value last written.
  assign level_rd = (direction_q & pin_sync) | (~direction_q & pin_level_q);

  always_comb
  begin
    case (word_idx)
      IDX_PIN_LEVEL: rd_byte = level_rd;
      IDX_DIRECTION: rd_byte = direction_q;
      IDX_CTRL_LOW: rd_byte = ctrl_low_q;
      IDX_CTRL_HIGH: rd_byte = ctrl_high_q;
      IDX_FSEL_LOW: rd_byte = fsel_low_q;
      IDX_FSEL_HIGH: rd_byte = fsel_high_q;
      IDX_MODE0: rd_byte = mode0_q;
      default: rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      dat_q <= '0;
    else if (access && !wb_we_i)
      dat_q <= {{(DATA_W-8){1'b0}}, rd_byte};
  end

  assign wb_dat_o = dat_q;
  assign wb_ack_o = ack_q;

  // ------------------------------------------------------------
  // Receive routing
  // ------------------------------------------------------------
  sync_2ff #(
    .WIDTH(PORT_W)
  ) u_pin_sync (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .async_i(pin_in_i),
    .sync_o(pin_sync)
  );

  // The select bit alone picks the source; a pin 5 set up for
  // receive is not heard while the bit is 0.
  assign rsel = mode0_q[RSEL_BIT];

  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      rx_q <= RX_IDLE;
    else
      rx_q <= rsel ? pin_sync[RX_PIN_B] : pin_sync[RX_PIN_A];
  end

  assign serial_rx_in_o = rx_q;
  assign receive_pin_select_o = mode0_q[RSEL_BIT];

  // ------------------------------------------------------------
  // Transmit routing and pad cells
  // ------------------------------------------------------------
  // Receive mode forces the level here rather than in each cell, so both
  // transmit pins agree and neither can be caught low in receive mode.
  assign tx_level = serial_rx_mode_i ? 1'b1 : serial_tx_out_i;

  always_comb
  begin
    serial_pin = '0;
    for (int n = 0; n < PORT_W; n++)
    begin
      if (n == TX_PIN_A || n == TX_PIN_B)
        serial_pin[n] = {fsel_high_q[n], fsel_low_q[n]} == FSEL_TERTIARY;
    end
  end

  // Every pin gets the same cell; only pins 1 and 4 can ever be handed to
  // the serial unit, all others stay plain port pins.
  for (genvar g = 0; g < PORT_W; g++)
  begin : g_pin
    port_pin_cell u_cell (
      .sys_clk_i(sys_clk_i),
      .rstn_i(rstn_i),
      .dir_i(direction_q[g]),
      .ctrl_i({ctrl_high_q[g], ctrl_low_q[g]}),
      .data_i(pin_level_q[g]),
      .serial_i(serial_pin[g]),
      .tx_level_i(tx_level),
      .out_o(pin_out_o[g]),
      .oe_o(pin_oe_o[g]),
      .pull_up_o(pin_pull_up_o[g]),
      .pull_down_o(pin_pull_down_o[g])
    );
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  // A pin set up as the serial transmit output: tertiary function,
  // output direction and push-pull drive.
  sequence tx_cmos(int p);
    fsel_high_q[p] && !fsel_low_q[p] && direction_q[p] == DIR_OUT
      && ctrl_high_q[p] && ctrl_low_q[p];
  endsequence

  a_tx_pin_one: assert property (
    tx_cmos(TX_PIN_A) and !serial_rx_mode_i
      |=> pin_oe_o[TX_PIN_A] && pin_out_o[TX_PIN_A] == $past(serial_tx_out_i))
    else $error("transmit not on pin 1");

  a_tx_pin_four: assert property (
    tx_cmos(TX_PIN_B) and !serial_rx_mode_i
      |=> pin_oe_o[TX_PIN_B] && pin_out_o[TX_PIN_B] == $past(serial_tx_out_i))
    else $error("transmit not on pin 4");

  // Receive mode parks both transmit pins high, so the far side sees an
  // idle line and never a false start bit.
  a_tx_idle_high: assert property (
    tx_cmos(TX_PIN_A) and serial_rx_mode_i |=> pin_out_o[TX_PIN_A])
    else $error("transmit pin low in receive mode");

  a_tx_idle_four: assert property (
    tx_cmos(TX_PIN_B) and serial_rx_mode_i |=> pin_out_o[TX_PIN_B])
    else $error("transmit pin 4 low in receive mode");

  // For two cycles after reset the receive line still shows what the
  // synchroniser was reset to; a low level there would read as a start bit.
  a_rx_idle_reset: assert property (
    !$past(rstn_i, 2) |-> serial_rx_in_o == RX_IDLE)
    else $error("receive line low after reset");

  // The three-cycle guard keeps these checks off until the synchroniser
  // and the receive register have both been refilled after reset.
  a_rx_from_zero: assert property (
    !rsel && $past(rstn_i, 3) |=> serial_rx_in_o == $past(pin_in_i[RX_PIN_A], 3))
    else $error("receive not from pin 0");

  a_rx_from_five: assert property (
    rsel && $past(rstn_i, 3) |=> serial_rx_in_o == $past(pin_in_i[RX_PIN_B], 3))
    else $error("receive not from pin 5");

  a_rx_override: assert property (
    !rsel && direction_q[RX_PIN_B] && $past(rstn_i, 3)
      && pin_in_i[RX_PIN_A] != pin_in_i[RX_PIN_B]
      ##1 !rsel [*3] |-> serial_rx_in_o == $past(pin_in_i[RX_PIN_A], 3))
    else $error("pin 5 heard while select is 0");

  a_rsel_write: assert property (
    wr_en && word_idx == IDX_MODE0 |=> receive_pin_select_o == $past(wb_dat_i[RSEL_BIT]))
    else $error("receive select bit not written");

  a_ack_single: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus answer not one cycle");

  // Main scenarios that the bench is expected to reach.
  c_tx_pin_one: cover property (tx_cmos(TX_PIN_A) ##1 pin_oe_o[TX_PIN_A]);
  c_rx_pin_five: cover property (rsel ##3 serial_rx_in_o != RX_IDLE);
  c_bus_write: cover property (wr_en ##1 wb_ack_o);
  c_tx_idle_four: cover property (
    (tx_cmos(TX_PIN_B) and serial_rx_mode_i) ##1 pin_out_o[TX_PIN_B]);
  c_rx_hold_zero: cover property (
    !rsel && direction_q[RX_PIN_B] && pin_in_i[RX_PIN_A] != pin_in_i[RX_PIN_B]);

endmodule : uart_port_pin_routing

// ---- bench/serial_peer.sv ----
module serial_peer (
  // Clock
  input wire logic sys_clk_i,
  // Peer drive
  input wire logic [7:0] drive_en_i,
  input wire logic [7:0] drive_val_i,
  // Device pads
  input wire logic [7:0] pin_out_i,
  input wire logic [7:0] pin_oe_i,
  input wire logic [7:0] pull_up_i,
  input wire logic [7:0] pull_down_i,
  // Wire levels
  output logic [7:0] pin_in_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // A line that nobody holds toggles, so a stale level never passes for a driven one.
  logic [7:0] float_q = 8'h55;

  always @(posedge sys_clk_i)
  begin
    float_q <= ~float_q;
  end

  always_comb
  begin
    for (int n = 0; n < 8; n++)
    begin
      if (pin_oe_i[n])
        pin_in_o[n] = pin_out_i[n];
      else if (drive_en_i[n])
        pin_in_o[n] = drive_val_i[n];
      else if (pull_up_i[n])
        pin_in_o[n] = 1'b1;
      else if (pull_down_i[n])
        pin_in_o[n] = 1'b0;
      else
        pin_in_o[n] = float_q[n];
    end
  end
endmodule : serial_peer

// ---- bench/tb_top.sv ----
module tb_top import pinmux_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [ADDR_W-1:0] adr = '0;
  logic [3:0] sel = 4'h0;
  logic [DATA_W-1:0] wdat = '0;
  logic [DATA_W-1:0] rdat;
  logic [DATA_W-1:0] rbuf;
  logic ack;
  logic tx_lvl = 1'b1;
  logic rx_mode = 1'b0;
  logic rx_in;
  logic rsel;
  logic [PORT_W-1:0] pin_in;
  logic [PORT_W-1:0] pin_out;
  logic [PORT_W-1:0] pin_oe;
  logic [PORT_W-1:0] pin_pu;
  logic [PORT_W-1:0] pin_pd;
  logic [PORT_W-1:0] peer_en = 8'h00;
  logic [PORT_W-1:0] peer_val = 8'h00;
  logic [31:0] lv;
  int num_errors = 0;
  int n_checks = 0;
  logic [15:0] idx_tab [7] = '{IDX_PIN_LEVEL, IDX_DIRECTION, IDX_CTRL_LOW, IDX_CTRL_HIGH,
    IDX_FSEL_LOW, IDX_FSEL_HIGH, IDX_MODE0};
  logic [15:0] cfg_idx [5] = '{IDX_DIRECTION, IDX_CTRL_HIGH, IDX_CTRL_LOW, IDX_FSEL_LOW,
    IDX_FSEL_HIGH};
  logic [7:0] cfg_a [5] = '{8'h01, 8'h0a, 8'h0a, 8'h00, 8'h02};
  logic [7:0] cfg_b [5] = '{8'h21, 8'h38, 8'h18, 8'h00, 8'h10};

  always #4 sys_clk = ~sys_clk;

  uart_port_pin_routing dut (
    .sys_clk_i(sys_clk),
    .rstn_i(rstn),
    .wb_cyc_i(cyc),
    .wb_stb_i(stb),
    .wb_we_i(we),
    .wb_adr_i(adr),
    .wb_sel_i(sel),
    .wb_dat_i(wdat),
    .wb_dat_o(rdat),
    .wb_ack_o(ack),
    .serial_tx_out_i(tx_lvl),
    .serial_rx_mode_i(rx_mode),
    .serial_rx_in_o(rx_in),
    .receive_pin_select_o(rsel),
    .pin_in_i(pin_in),
    .pin_out_o(pin_out),
    .pin_oe_o(pin_oe),
    .pin_pull_up_o(pin_pu),
    .pin_pull_down_o(pin_pd)
  );

  serial_peer peer (
    .sys_clk_i(sys_clk),
    .drive_en_i(peer_en),
    .drive_val_i(peer_val),
    .pin_out_i(pin_out),
    .pin_oe_i(pin_oe),
    .pull_up_i(pin_pu),
    .pull_down_i(pin_pd),
    .pin_in_o(pin_in)
  );

  // ----------------------------------------
  // Expectations and bus tasks
  // ----------------------------------------
  function automatic logic exp_rx(input logic s, input logic [7:0] p);
    return s ? p[RX_PIN_B] : p[RX_PIN_A];
  endfunction : exp_rx

  // Receive mode parks the transmit line high.
  function automatic logic exp_tx(input logic m, input logic t);
    return m | t;
  endfunction : exp_tx

  task automatic chkw(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e)
    begin
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
      num_errors++;
    end
  endtask : chkw

  task automatic chkb(input logic g, input logic e);
    chkw({31'h0, g}, {31'h0, e});
  endtask : chkb

  task automatic xfer(input logic w, input logic [15:0] i, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {i, 2'b00};
    sel <= 4'h1;
    wdat <= {24'h0, d};
    do
    begin
      @(posedge sys_clk);
      n++;
    end while (ack !== 1'b1 && n < 40);
    chkb(ack, 1'b1);
    rbuf = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : xfer

  task automatic run_phase(input logic b);
    logic [31:0] v;
    logic s;
    int tp;
    tp = b ? TX_PIN_B : TX_PIN_A;
    for (int k = 0; k < 5; k++)
      xfer(1'b1, cfg_idx[k], b ? cfg_b[k] : cfg_a[k]);
    for (int k = 0; k < 8; k++)
    begin
      v = $urandom;
      tx_lvl <= v[0];
      rx_mode <= v[1];
      peer_val <= v[15:8];
      xfer(1'b1, IDX_PIN_LEVEL, v[23:16]);
      xfer(1'b1, IDX_MODE0, b ? v[31:24] : 8'h00);
      repeat (5) @(posedge sys_clk);
      s = b & v[28];
      chkb(pin_out[tp], exp_tx(v[1], v[0]));
      chkb(pin_oe[tp], 1'b1);
      chkb(pin_oe[b ? TX_PIN_A : TX_PIN_B], 1'b0);
      chkb(pin_oe[RX_PIN_A], 1'b0);
      chkb(pin_oe[RX_PIN_B], 1'b0);
      chkb(pin_pu[RX_PIN_B], b);
      chkb(pin_pd[RX_PIN_B], 1'b0);
      chkb(rsel, s);
      chkb(rx_in, exp_rx(s, v[15:8]));
      chkb(pin_out[3], v[19]);
      chkb(pin_oe[3], 1'b1);
    end
  endtask : run_phase

  task automatic results;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : results

  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial
  begin
    lv = $urandom(27);
    repeat (16) @(posedge sys_clk);
    rstn <= 1'b1;
    chkb(rx_in, RX_IDLE);
    chkb(rsel, 1'b0);
    chkw({24'h0, pin_oe}, 32'h0);
    for (int k = 0; k < 7; k++)
    begin
      xfer(1'b0, idx_tab[k], 8'h00);
      chkw(rbuf, {24'h0, (k == 6) ? RST_MODE0 : RST_PORT});
    end
    // Pin level goes first, while every pin is still an output and reads back its register.
    for (int k = 0; k < 7; k++)
    begin
      lv = $urandom;
      xfer(1'b1, idx_tab[k], lv[7:0]);
      xfer(1'b0, idx_tab[k], 8'h00);
      chkw(rbuf, {24'h0, lv[7:0]});
    end
    xfer(1'b1, 16'h0100, 8'hff);
    xfer(1'b0, 16'h0100, 8'h00);
    chkw(rbuf, 32'h0);
    peer_en <= 8'h21;
    run_phase(1'b0);
    run_phase(1'b1);
    results();
  end

  initial
  begin
    #50000;
    num_errors++;
    results();
  end
endmodule : tb_top
